// ---- stopwatch_defs.vh ----
`ifndef STOPWATCH_DEFS_VH
`define STOPWATCH_DEFS_VH
// Command codes for the stopwatch register
`define SW_CMD_READ 8'h6C
`define SW_CMD_WRITE 8'hEC
// Field positions
`define SW_RUN_BIT 31
`define SW_COUNT_MSB 23
`define SW_COUNT_WIDTH 24
`define SW_RESV_MSB 30
`define SW_RESV_LSB 24
// Reset values
`define SW_COUNT_RESET 24'h000000
`define SW_RUN_RESET 1'b0
// Terminal count
`define SW_TERMINAL 24'h0FFFFF
// Tick period in nanoseconds (0.01 ms) and clock period in nanoseconds
`define SW_TICK_NS 10000
`define SW_CLK_NS 100
`define SW_TICK_CYCLES (`SW_TICK_NS / `SW_CLK_NS)
// Event enable layout
`define SW_EVT_WIDTH 11
`define SW_TIMEOUT_EVT_BIT 10
`endif

// ---- otg_event_stopwatch_timer.v ----
// Overview of operation
// - Writing run bit clears count, starts counting
// - At FFFFF hex, stop and clear run
// - Writing zero to run bit halts counting
// - Enabled pending event stops and latches count
// - Count field reads bits 23:0, 0.01 ms units
// - Read code 6C, write code EC
// - Each event source has its own enable
`timescale 1ns/10ps
`include "stopwatch_defs.vh"
module otg_event_stopwatch_timer #(
	parameter TICK_CYCLES = `SW_TICK_CYCLES,
	parameter EVT_WIDTH = `SW_EVT_WIDTH,
	parameter TERMINAL_COUNT = `SW_TERMINAL
)(
	input wire clk,
	input wire rst,
	input wire cmd_valid,
	input wire [7:0] cmd_code,
	input wire [31:0] cmd_wdata,
	input wire [EVT_WIDTH-1:0] otg_event_status,
	input wire [EVT_WIDTH-1:0] otg_event_enable,
	output reg [31:0] rdata_r,
	output reg rdata_valid_r,
	output reg stopwatch_run_bit_r,
	output reg [`SW_COUNT_MSB:0] count_r
);

// Prescaler compares at full parameter width, so no bits are dropped
localparam [31:0] TICK_LAST = TICK_CYCLES - 1;
localparam [31:0] PRESC_STEP = 32'h00000001;
localparam [31:0] PRESC_ZERO = 32'h00000000;
// Count arithmetic constants
localparam [`SW_COUNT_MSB:0] COUNT_STEP = 24'h000001;
localparam [`SW_COUNT_MSB:0] COUNT_ZERO = `SW_COUNT_RESET;
// Reserved field width and its read value
localparam RESV_WIDTH = `SW_RESV_MSB - `SW_RESV_LSB + 1;
localparam [RESV_WIDTH-1:0] RESV_ZERO = {RESV_WIDTH{1'b0}};

// Prescaler state and tick strobe
reg [31:0] presc_r;
reg [31:0] presc_nxt;
reg tick;
// Next values of run bit and count
reg run_nxt;
reg [`SW_COUNT_MSB:0] count_nxt;
// Next values of the read answer
reg [31:0] rdata_nxt;
reg rdata_valid_nxt;
// Decoded commands
wire wr_hit;
wire rd_hit;
wire start_req;
wire stop_req;
// Event gating per source
wire [EVT_WIDTH-1:0] evt_gated;
wire evt_hit;
// Terminal detection
wire [`SW_COUNT_MSB:0] count_inc;
wire at_terminal;
wire next_terminal;
genvar g;

// Command decode; every other code is ignored without indication
assign wr_hit = cmd_valid && (cmd_code == `SW_CMD_WRITE);
assign rd_hit = cmd_valid && (cmd_code == `SW_CMD_READ);
assign start_req = wr_hit && cmd_wdata[`SW_RUN_BIT];
assign stop_req = wr_hit && !cmd_wdata[`SW_RUN_BIT];

// One gate per event source; each source has its own enable bit
generate
	for (g = 0; g < EVT_WIDTH; g = g + 1)
	begin : gate_loop
		assign evt_gated[g] = otg_event_status[g] & otg_event_enable[g];
	end
endgenerate
// Live inputs, no history: a pulse of one cycle while running is enough
assign evt_hit = |evt_gated;

// Terminal value is 20 bits wide although the field has 24
assign count_inc = count_r + COUNT_STEP;
assign at_terminal = (count_r == TERMINAL_COUNT);
assign next_terminal = (count_inc == TERMINAL_COUNT);

// Prescaler restarts with each start so the first tick is a full period;
// it holds while stopped. The tick is only 0.01 ms if TICK_CYCLES fits clk
always @*
begin
	tick = 1'b0;
	presc_nxt = presc_r;
	if (start_req)
	begin
		presc_nxt = PRESC_ZERO;
	end
	else if (stopwatch_run_bit_r)
	begin
		if (presc_r == TICK_LAST)
		begin
			presc_nxt = PRESC_ZERO;
			tick = 1'b1;
		end
		else
		begin
			presc_nxt = presc_r + PRESC_STEP;
		end
	end
end

// Run bit next value; a software write wins over an event in one cycle
always @*
begin
	run_nxt = stopwatch_run_bit_r;
	if (start_req)
	begin
		run_nxt = 1'b1;
	end
	else if (stop_req)
	begin
		run_nxt = 1'b0;
	end
	else if (stopwatch_run_bit_r)
	begin
		if (evt_hit)
		begin
			run_nxt = 1'b0;
		end
		else if (at_terminal)
		begin
			run_nxt = 1'b0;
		end
		else if (tick && next_terminal)
		begin
			run_nxt = 1'b0;
		end
	end
end

// Count next value; an event or a stop freezes it for software to read
always @*
begin
	count_nxt = count_r;
	if (start_req)
	begin
		count_nxt = COUNT_ZERO;
	end
	else if (stop_req)
	begin
		count_nxt = count_r;
	end
	else if (stopwatch_run_bit_r && !evt_hit && !at_terminal && tick)
	begin
		count_nxt = count_inc;
	end
end

// Read answer; data holds until the next read, reserved bits read zero
always @*
begin
	rdata_nxt = rdata_r;
	rdata_valid_nxt = 1'b0;
	if (rd_hit)
	begin
		rdata_nxt = {stopwatch_run_bit_r, RESV_ZERO, count_r};
		rdata_valid_nxt = 1'b1;
	end
end

// Prescaler register
always @(posedge clk)
begin
	if (rst)
	begin
		presc_r <= PRESC_ZERO;
	end
	else
	begin
		presc_r <= presc_nxt;
	end
end

// Run bit register
always @(posedge clk)
begin
	if (rst)
	begin
		stopwatch_run_bit_r <= `SW_RUN_RESET;
	end
	else
	begin
		stopwatch_run_bit_r <= run_nxt;
	end
end

// Count register; the frozen value stays until the next start
always @(posedge clk)
begin
	if (rst)
	begin
		count_r <= `SW_COUNT_RESET;
	end
	else
	begin
		count_r <= count_nxt;
	end
end

// Read answer registers, one cycle after the command
always @(posedge clk)
begin
	if (rst)
	begin
		rdata_r <= 32'h00000000;
		rdata_valid_r <= 1'b0;
	end
	else
	begin
		rdata_r <= rdata_nxt;
		rdata_valid_r <= rdata_valid_nxt;
	end
end

endmodule

// ---- sw_props.sv ----
`timescale 1ns/10ps
module sw_props #(parameter EVT_WIDTH=11,parameter [23:0] TERMINAL_COUNT=24'h0FFFFF)
(input clk,rst,cmd_valid,rdata_valid_r,
stopwatch_run_bit_r,input [7:0] cmd_code,input [31:0] cmd_wdata,rdata_r,
input [EVT_WIDTH-1:0] otg_event_status,otg_event_enable,input [23:0] count_r);
default clocking @(posedge clk); endclocking
default disable iff (rst);
wire u=stopwatch_run_bit_r,w=cmd_valid&&cmd_code==8'hEC,r=cmd_valid&&cmd_code==8'h6C;
wire [23:0] n=count_r;
a_start_zero: assert property(w&&cmd_wdata[31]|=>u&&!n) else $error("start");
a_end_stop: assert property(n==TERMINAL_COUNT|->!u) else $error("end");
a_stop_write: assert property(w&&!cmd_wdata[31]|=>!u) else $error("stop");
a_event_stop: assert property(u&&|(otg_event_status&otg_event_enable)&&!w|=>!u)
	else $error("event");
a_hold_count: assert property(!u&&!w|=>$stable(n)) else $error("hold");
a_count_step: assert property($changed(n)|->!n||n==$past(n)+24'h1) else $error("step");
a_read_word: assert property(r|=>rdata_valid_r&&rdata_r=={$past(u),7'h00,$past(n)})
	else $error("read");
a_read_pulse: assert property(!r|=>!rdata_valid_r) else $error("pulse");
cover property(u);
cover property(r);
cover property(w&&!cmd_wdata[31]);
cover property(n==TERMINAL_COUNT);
endmodule
bind otg_event_stopwatch_timer sw_props #(.EVT_WIDTH(EVT_WIDTH),
.TERMINAL_COUNT(TERMINAL_COUNT)) sw_props_inst(.*);

// ---- otg_event_stopwatch_timer_tb.sv ----
`timescale 1ns/10ps
module otg_event_stopwatch_timer_tb;
localparam integer TICK=4;
localparam [23:0] TERM=24'h000040;
localparam integer NEVER=32'h7FFFFFFF;
reg clk=0,rst=1,v=0;
reg [7:0] c=0,k;
reg [31:0] d=0;
reg [10:0] s=0,e=0;
wire [31:0] q;
wire qv,run;
wire [23:0] cnt;
integer fail_count=0,checks=0,i,t=0,tk=0,ts=0,sp=0,seed=32'h9FE4;
always #50 clk=~clk;
// Edge counter and ceiling, far above the fewer than 2000 cycles needed
always @(posedge clk) if(++t>8000) complete_run(1);
otg_event_stopwatch_timer #(.TICK_CYCLES(TICK),.TERMINAL_COUNT(TERM))
otg_event_stopwatch_timer_inst(.clk(clk),.rst(rst),
.cmd_valid(v),.cmd_code(c),.cmd_wdata(d),.otg_event_status(s),.otg_event_enable(e),
.rdata_r(q),.rdata_valid_r(qv),.stopwatch_run_bit_r(run),.count_r(cnt));
task complete_run(input f);
begin
	fail_count+=f;
	$display("fail_count=%0d checks=%0d",fail_count,checks);
	if(fail_count==0&&checks>0) $display("== PASSED ==");
	else $display("== FAILED ==");
	$finish;
end
endtask
task chk(input [31:0] a,b);
begin
	checks++;
	if(a!==b)
	begin
		fail_count++;
		$display("unexpected %0t %h %h",$time,a,b);
	end
end
endtask
// One idle cycle between commands keeps strobes clean; tk is the taking edge
task cmd(input [7:0] a,input [31:0] w);
begin
	@(negedge clk) {v,c,d}={1'b1,a,w};
	@(negedge clk) v=0;
	tk=t;
end
endtask
// Count after edge n: ticks since start, frozen by a stop, capped at terminal
function [23:0] ecnt(input integer n);
integer m;
begin
	m=((n<sp)?n:sp-1)-ts;
	ecnt=(m/TICK>TERM)?TERM:m/TICK;
end
endfunction
// Run bit after edge n
function erun(input integer n);
	erun=(n<sp)&&((n-ts)/TICK<TERM);
endfunction
// Read, then compare answer, pulse and live outputs against the model
task rd;
begin
	cmd(8'h6C,0);
	chk(qv,1);
	chk(q,{erun(tk-1),7'h00,ecnt(tk-1)});
	chk({run,cnt},{erun(tk),ecnt(tk)});
	@(negedge clk) chk(qv,0);
end
endtask
initial
begin
	repeat(10) @(negedge clk);
	rst=0;
	for(i=0;i<30;i++)
	begin
		cmd(8'hEC,$random(seed)|32'h80000000);
		ts=tk;
		sp=NEVER;
		// Second pass runs long enough to reach the terminal count
		repeat((i==1)?300:{$random(seed)}%40) @(negedge clk);
		// Foreign code with the run bit set must not restart the count
		k=$random(seed);
		if(k==8'hEC||k==8'h6C) k=k^8'h01;
		cmd(k,32'hFFFFFFFF);
		{s,e}=i?{11'h1<<{$random(seed)}%11,11'($random(seed))}:22'h200400;
		if((|(s&e))&&(t+1<sp)) sp=t+1;
		@(negedge clk) s=0;
		rd;
		cmd(8'hEC,0);
		if(tk<sp) sp=tk;
		rd;
	end
	// Reset in mid-run clears everything; a start right after must work
	cmd(8'hEC,32'h80000000);
	repeat(20) @(negedge clk);
	rst=1;
	repeat(2) @(negedge clk);
	rst=0;
	chk(q,0);
	chk({qv,run,cnt},0);
	@(negedge clk) chk({run,cnt},0);
	cmd(8'hEC,32'h80000000);
	ts=tk;
	sp=NEVER;
	repeat(9) @(negedge clk);
	rd;
	complete_run(0);
end
endmodule
